// >>> gpcd_regs.v
// Register file and pad control for general-purpose ports C and D
`timescale 1ns/1ps
`default_nettype none
`include "gpcd_consts.vh"

// Summary of operation
// - Unimplemented bit positions read zero; writes to them are ignored.
// - On 64-pin parts, port C bits 1-4 and port D 12-15 read zero.
// - Port C pins 12, 15 work only in oscillator modes 11 or 00.
// - Port C pin 15 also needs the oscillator output function bit set.
// - Port C direction register resets to F01E.
// - Port D direction register resets to FFFF.
// - Both open-drain select registers reset to 0000.
// - Output latch resets to 0000; pin-level contents follow the synchronised pads.
// - Reset values hold for 100-pin; smaller parts read absent bits zero.
module gpcd_regs
#(
    parameter ADDR_WIDTH = 16,
    parameter WIDTH = 16
)
(
    input wire mclk,
    input wire resetn,
    input wire [ADDR_WIDTH-1:0] regAddr,
    input wire [WIDTH-1:0] regWrData,
    input wire regWrEn,
    input wire regRdEn,
    output reg [WIDTH-1:0] regRdData_ff,
    input wire pkgIs64Pin,
    input wire [1:0] primaryOscModeSetting,
    input wire oscOutputFunctionBit,
    input wire [WIDTH-1:0] portCPinIn,
    output wire [WIDTH-1:0] portCPinOut,
    output wire [WIDTH-1:0] portCPinOe,
    input wire [WIDTH-1:0] portDPinIn,
    output wire [WIDTH-1:0] portDPinOut,
    output wire [WIDTH-1:0] portDPinOe
);

    wire [WIDTH-1:0] portCPinLevel;
    wire [WIDTH-1:0] portDPinLevel;
    wire [3:0] cfgSync;
    wire cfgIs64Pin;
    wire [1:0] cfgOscMode;
    wire cfgOscOutFn;

    wire [WIDTH-1:0] cDir;
    wire [WIDTH-1:0] cLat;
    wire [WIDTH-1:0] cOdc;
    wire [WIDTH-1:0] dDir;
    wire [WIDTH-1:0] dLat;
    wire [WIDTH-1:0] dOdc;

    wire [WIDTH-1:0] cStoreMask;
    wire [WIDTH-1:0] dStoreMask;
    wire [WIDTH-1:0] cPinMask;
    wire oscPinsFree;
    wire pin15Free;

    wire selCDir;
    wire selCPin;
    wire selCLat;
    wire selCOdc;
    wire selDDir;
    wire selDPin;
    wire selDLat;
    wire selDOdc;

    reg [WIDTH-1:0] nxt_regRdData;

    // Pads come from outside the clock domain
    gpcd_sync #(.WIDTH(WIDTH)) uSyncC
    (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn(portCPinIn),
        .syncOut_ff(portCPinLevel)
    );

    gpcd_sync #(.WIDTH(WIDTH)) uSyncD
    (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn(portDPinIn),
        .syncOut_ff(portDPinLevel)
    );

    // Configuration levels are static but synchronised anyway for safety
    gpcd_sync #(.WIDTH(4)) uSyncCfg
    (
        .mclk(mclk),
        .resetn(resetn),
        .asyncIn({pkgIs64Pin, primaryOscModeSetting, oscOutputFunctionBit}),
        .syncOut_ff(cfgSync)
    );

    assign cfgIs64Pin = cfgSync[3];
    assign cfgOscMode = cfgSync[2:1];
    assign cfgOscOutFn = cfgSync[0];

    // Package decides which positions exist in all four registers
    assign cStoreMask = cfgIs64Pin ? (`GPCD_IMPL_C & ~`GPCD_ABSENT64_C)
        : `GPCD_IMPL_C;
    assign dStoreMask = cfgIs64Pin ? (`GPCD_IMPL_D & ~`GPCD_ABSENT64_D)
        : `GPCD_IMPL_D;

    // Oscillator pins lose their I/O role while the oscillator owns them
    assign oscPinsFree = (cfgOscMode == `GPCD_OSC_DISABLED)
        || (cfgOscMode == `GPCD_OSC_EXT_CLOCK);
    assign pin15Free = oscPinsFree & cfgOscOutFn;
    assign cPinMask = cStoreMask
        & ~(oscPinsFree ? `GPCD_ZERO : `GPCD_OSC_PIN12)
        & ~(pin15Free ? `GPCD_ZERO : `GPCD_OSC_PIN15);

    assign selCDir = (regAddr == `GPCD_ADDR_C_DIR);
    assign selCPin = (regAddr == `GPCD_ADDR_C_PIN);
    assign selCLat = (regAddr == `GPCD_ADDR_C_LAT);
    assign selCOdc = (regAddr == `GPCD_ADDR_C_ODC);
    assign selDDir = (regAddr == `GPCD_ADDR_D_DIR);
    assign selDPin = (regAddr == `GPCD_ADDR_D_PIN);
    assign selDLat = (regAddr == `GPCD_ADDR_D_LAT);
    assign selDOdc = (regAddr == `GPCD_ADDR_D_ODC);

    // A write to the pin-level address lands in the output latch
    gpcd_port #(.WIDTH(WIDTH), .DIR_RESET(`GPCD_RST_C_DIR)) uPortC
    (
        .mclk(mclk),
        .resetn(resetn),
        .wrDir(regWrEn & selCDir),
        .wrLat(regWrEn & (selCLat | selCPin)),
        .wrOdc(regWrEn & selCOdc),
        .wrData(regWrData),
        .storeMask(cStoreMask),
        .driveMask(cPinMask),
        .dir_ff(cDir),
        .lat_ff(cLat),
        .odc_ff(cOdc),
        .pinOut_ff(portCPinOut),
        .pinOe_ff(portCPinOe)
    );

    gpcd_port #(.WIDTH(WIDTH), .DIR_RESET(`GPCD_RST_D_DIR)) uPortD
    (
        .mclk(mclk),
        .resetn(resetn),
        .wrDir(regWrEn & selDDir),
        .wrLat(regWrEn & (selDLat | selDPin)),
        .wrOdc(regWrEn & selDOdc),
        .wrData(regWrData),
        .storeMask(dStoreMask),
        .driveMask(dStoreMask),
        .dir_ff(dDir),
        .lat_ff(dLat),
        .odc_ff(dOdc),
        .pinOut_ff(portDPinOut),
        .pinOe_ff(portDPinOe)
    );

    // Read masks also hide reset values of bits a small package lacks
    always @*
    begin
        nxt_regRdData = `GPCD_ZERO;
        if (regRdEn)
        begin
            if (selCDir)
                nxt_regRdData = cDir & cStoreMask;
            else if (selCPin)
                nxt_regRdData = portCPinLevel & cPinMask;
            else if (selCLat)
                nxt_regRdData = cLat & cStoreMask;
            else if (selCOdc)
                nxt_regRdData = cOdc & cStoreMask;
            else if (selDDir)
                nxt_regRdData = dDir & dStoreMask;
            else if (selDPin)
                nxt_regRdData = portDPinLevel & dStoreMask;
            else if (selDLat)
                nxt_regRdData = dLat & dStoreMask;
            else if (selDOdc)
                nxt_regRdData = dOdc & dStoreMask;
        end
    end

    // Data stand only in the cycle after the read strobe
    always @(posedge mclk)
    begin
        if (!resetn)
            regRdData_ff <= `GPCD_ZERO;
        else
            regRdData_ff <= nxt_regRdData;
    end

endmodule

`default_nettype wire

// >>> gpcd_consts.vh
// Address map, reset values and bit masks of the port C and D registers
`ifndef GPCD_CONSTS_VH
`define GPCD_CONSTS_VH

`define GPCD_ADDR_C_DIR 16'h02D0
`define GPCD_ADDR_C_PIN 16'h02D2
`define GPCD_ADDR_C_LAT 16'h02D4
`define GPCD_ADDR_C_ODC 16'h02D6
`define GPCD_ADDR_D_DIR 16'h02D8
`define GPCD_ADDR_D_PIN 16'h02DA
`define GPCD_ADDR_D_LAT 16'h02DC
`define GPCD_ADDR_D_ODC 16'h02DE

`define GPCD_RST_C_DIR 16'hF01E
`define GPCD_RST_D_DIR 16'hFFFF
`define GPCD_RST_ODC 16'h0000
`define GPCD_RST_LAT 16'h0000
`define GPCD_ZERO 16'h0000

`define GPCD_IMPL_C 16'hF01E
`define GPCD_IMPL_D 16'hFFFF
`define GPCD_ABSENT64_C 16'h001E
`define GPCD_ABSENT64_D 16'hF000
`define GPCD_OSC_PIN12 16'h1000
`define GPCD_OSC_PIN15 16'h8000

`define GPCD_OSC_DISABLED 2'h3
`define GPCD_OSC_EXT_CLOCK 2'h0

`endif

// >>> gpcd_sync.v
// Two-stage synchroniser for a bus of independent levels
`timescale 1ns/1ps
`default_nettype none

module gpcd_sync
#(
    parameter WIDTH = 16
)
(
    input wire mclk,
    input wire resetn,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut_ff
);

    reg [WIDTH-1:0] stage1_ff;

    // Stage one is read by stage two only
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            stage1_ff <= {WIDTH{1'b0}};
            syncOut_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1_ff <= asyncIn;
            syncOut_ff <= stage1_ff;
        end
    end

endmodule

`default_nettype wire

// >>> gpcd_port.v
// One I/O port: direction, latch and open-drain storage plus pad drive
`timescale 1ns/1ps
`default_nettype none
`include "gpcd_consts.vh"

module gpcd_port
#(
    parameter WIDTH = 16,
    parameter [WIDTH-1:0] DIR_RESET = `GPCD_RST_D_DIR
)
(
    input wire mclk,
    input wire resetn,
    input wire wrDir,
    input wire wrLat,
    input wire wrOdc,
    input wire [WIDTH-1:0] wrData,
    input wire [WIDTH-1:0] storeMask,
    input wire [WIDTH-1:0] driveMask,
    output reg [WIDTH-1:0] dir_ff,
    output reg [WIDTH-1:0] lat_ff,
    output reg [WIDTH-1:0] odc_ff,
    output reg [WIDTH-1:0] pinOut_ff,
    output reg [WIDTH-1:0] pinOe_ff
);

    wire [WIDTH-1:0] nxt_pinOut;
    wire [WIDTH-1:0] nxt_pinOe;

    // Absent positions keep their old value, so writes there do nothing
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            dir_ff <= DIR_RESET;
            lat_ff <= `GPCD_RST_LAT;
            odc_ff <= `GPCD_RST_ODC;
        end
        else
        begin
            if (wrDir)
                dir_ff <= (wrData & storeMask) | (dir_ff & ~storeMask);
            if (wrLat)
                lat_ff <= (wrData & storeMask) | (lat_ff & ~storeMask);
            if (wrOdc)
                odc_ff <= (wrData & storeMask) | (odc_ff & ~storeMask);
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : gBit
            // Open drain only ever pulls low; a one floats the pad
            assign nxt_pinOut[i] = odc_ff[i] ? 1'b0 : lat_ff[i];
            assign nxt_pinOe[i] = driveMask[i] & ~dir_ff[i]
                & (~odc_ff[i] | ~lat_ff[i]);
        end
    endgenerate

    // Pads stay undriven during reset so every pin starts as input
    always @(posedge mclk)
    begin
        if (!resetn)
        begin
            pinOut_ff <= {WIDTH{1'b0}};
            pinOe_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff <= nxt_pinOe;
        end
    end

endmodule

`default_nettype wire

// >>> gpcd_regs_placeholder_none.v
// Intentionally empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> gpcd_pads.sv
// Pad model for one port: board pull plus the block's own drive
`timescale 1ns/1ps
`default_nettype none
module gpcd_pads (
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOe,
    input wire logic [15:0] pullLevel,
    output logic [15:0] pinIn
);
    // Released pads fall to the board pull, never the last driven value
    assign pinIn = (pinOut & pinOe) | (pullLevel & ~pinOe);
endmodule
`default_nettype wire

// >>> gpcd_props.sv
// Port checker for the port C and D register block
`timescale 1ns/1ps
`default_nettype none
module gpcd_props (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regRdData_ff,
    input wire logic pkgIs64Pin,
    input wire logic [1:0] primaryOscModeSetting,
    input wire logic oscOutputFunctionBit,
    input wire logic [15:0] portCPinOe,
    input wire logic [15:0] portDPinOe,
    input wire logic [15:0] portDPinOut
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    a_c_unimpl_zero: assert property ($past(regRdEn) &&
        $past(regAddr[15:3]) == 13'h005A |-> (regRdData_ff & 16'h0FE1) == 0)
        else $error("port C unimplemented bit read nonzero");
    a_unmapped_zero: assert property ($past(regRdEn) &&
        $past(regAddr) > 16'h02DF |-> regRdData_ff == 16'h0000)
        else $error("unmapped read nonzero");
    a_c_small_pkg: assert property ($past(regRdEn) &&
        $past(regAddr[15:3]) == 13'h005A && $past(pkgIs64Pin, 4) &&
        $past(pkgIs64Pin) |-> (regRdData_ff & 16'h001E) == 0)
        else $error("port C absent bits read nonzero");
    a_d_small_pkg: assert property ($past(regRdEn) &&
        $past(regAddr[15:3]) == 13'h005B && $past(pkgIs64Pin, 4) &&
        $past(pkgIs64Pin) |-> (regRdData_ff & 16'hF000) == 0)
        else $error("port D absent bits read nonzero");
    a_pads_reset_off: assert property (!$past(resetn) |=>
        portCPinOe == 16'h0000 && portDPinOe == 16'h0000)
        else $error("pad driven right after reset");
    a_d_drive_still: assert property (!$past(regWrEn) &&
        !$past(regWrEn, 2) && $past(pkgIs64Pin, 4) == pkgIs64Pin
        |-> $stable(portDPinOe) && $stable(portDPinOut))
        else $error("port D drive changed without a write");
    a_osc_mode_mask: assert property ($past(regRdEn) &&
        $past(regAddr) == 16'h02D2 && ^$past(primaryOscModeSetting, 4) &&
        ^$past(primaryOscModeSetting) |-> (regRdData_ff & 16'h9000) == 0)
        else $error("oscillator pins readable in oscillator mode");
    a_osc_fn_mask: assert property ($past(regRdEn) &&
        $past(regAddr) == 16'h02D2 && !$past(oscOutputFunctionBit, 4) &&
        !$past(oscOutputFunctionBit) |-> !regRdData_ff[15])
        else $error("pin fifteen readable with function bit clear");
endmodule
bind gpcd_regs gpcd_props u_props (.mclk, .resetn, .regAddr, .regWrEn,
    .regRdEn, .regRdData_ff, .pkgIs64Pin, .primaryOscModeSetting,
    .oscOutputFunctionBit, .portCPinOe, .portDPinOe, .portDPinOut);
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the port C and D register block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [15:0] regWrData = 16'h0000;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic pkgIs64Pin = 1'b0;
    logic [1:0] primaryOscModeSetting = 2'h3;
    logic oscOutputFunctionBit = 1'b1;
    wire logic [15:0] regRdData_ff, portCPinIn, portCPinOut, portCPinOe;
    wire logic [15:0] portDPinIn, portDPinOut, portDPinOe;
    int n_errors = 0;
    int samples_checked = 0;
    always #5 mclk = ~mclk;
    gpcd_regs u_dut (.mclk, .resetn, .regAddr, .regWrData, .regWrEn,
        .regRdEn, .regRdData_ff, .pkgIs64Pin, .primaryOscModeSetting,
        .oscOutputFunctionBit, .portCPinIn, .portCPinOut, .portCPinOe,
        .portDPinIn, .portDPinOut, .portDPinOe);
    // Pulled up, so floating open-drain bits read one
    gpcd_pads u_padC (.pinOut(portCPinOut), .pinOe(portCPinOe),
        .pullLevel(16'hFFFF), .pinIn(portCPinIn));
    gpcd_pads u_padD (.pinOut(portDPinOut), .pinOe(portDPinOe),
        .pullLevel(16'hFFFF), .pinIn(portDPinIn));
    task automatic give_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData_ff, exp);
    endtask
    // Config and pad levels pass two sync stages first
    task automatic settle;
        repeat (4) @(posedge mclk);
    endtask
    task automatic t_reset_values;
        rd(16'h02D0, 16'hF01E);
        rd(16'h02D8, 16'hFFFF);
        rd(16'h02D6, 16'h0000);
        rd(16'h02DE, 16'h0000);
    endtask
    task automatic t_unimpl;
        wr(16'h02D0, 16'h0FE1);
        rd(16'h02D0, 16'h0000);
        wr(16'h02D0, 16'hFFFF);
        rd(16'h02D0, 16'hF01E);
        wr(16'h02E0, 16'h1234);
        rd(16'h02E0, 16'h0000);
    endtask
    task automatic t_drive;
        wr(16'h02D8, 16'h0000);
        wr(16'h02DC, 16'h00A5);
        settle;
        #1;
        chk(portDPinOe, 16'hFFFF);
        chk(portDPinOut, 16'h00A5);
        rd(16'h02DA, 16'h00A5);
        wr(16'h02DE, 16'hFFFF);
        settle;
        #1;
        chk(portDPinOe, 16'hFF5A);
        chk(portDPinOut, 16'h0000);
        rd(16'h02DA, 16'h00A5);
        wr(16'h02D0, 16'h0000);
        wr(16'h02D4, 16'h1234);
        settle;
        #1;
        chk(portCPinOe, 16'hF01E);
        chk(portCPinOut, 16'h1014);
        rd(16'h02D2, 16'h1014);
        // Back to inputs so the oscillator scenario sees the pull level
        wr(16'h02D0, 16'hFFFF);
    endtask
    task automatic t_osc;
        for (int m = 0; m < 4; m++)
            for (int f = 0; f < 2; f++)
            begin
                primaryOscModeSetting <= m[1:0];
                oscOutputFunctionBit <= f[0];
                settle;
                rd(16'h02D2, (m == 1 || m == 2) ? 16'h601E :
                    (f == 1 ? 16'hF01E : 16'h701E));
            end
    endtask
    task automatic t_pkg64;
        pkgIs64Pin <= 1'b1;
        settle;
        rd(16'h02D0, 16'hF000);
        wr(16'h02D8, 16'hFFFF);
        rd(16'h02D8, 16'h0FFF);
        rd(16'h02D2, 16'hF000);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        t_reset_values;
        t_unimpl;
        t_drive;
        t_osc;
        t_pkg64;
        give_verdict;
    end
    initial
    begin
        #20000;
        n_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
